// *** rtl/ofd_operand_decoder.v ***
`timescale 1ns/100ps
`default_nettype none
`include "ofd_defs.vh"
module ofd_operand_decoder (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [15:0] instr_word,
	input  wire [3:0]  instr_fmt,
	input  wire        instr_valid,
	input  wire        mul_valid,
	input  wire [15:0] mul_result,
	output wire        cycle_start,
	output reg         dec_valid,
	output reg  [11:0] data_addr,
	output reg  [7:0]  bit_sel,
	output reg         to_accum,
	output reg         to_file,
	output reg  [11:0] move_src,
	output reg  [11:0] move_dst,
	output reg         move_go,
	output reg  [19:0] imm_value,
	output reg  [1:0]  imm_width,
	output reg  [19:0] jump_target,
	output reg         jump_rel,
	output reg         jump_abs,
	output reg         shadow_save,
	output reg         shadow_restore,
	output reg  [20:0] tbl_addr,
	output reg         tbl_go,
	output reg         lone_nop,
	input  wire [3:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [3:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready
);
	localparam SEC_NONE = 3'h0;
	localparam SEC_MOVE = 3'h1;
	localparam SEC_GOTO = 3'h2;
	localparam SEC_CALL = 3'h3;
	localparam SEC_LIT  = 3'h4;

	reg  [1:0]  phase_reg;
	reg  [2:0]  sec_reg;
	reg         sfast_reg;
	reg  [3:0]  bank_reg;
	reg  [20:0] tptr_reg;
	reg  [15:0] prod_reg;
	reg         aw_hold_reg;
	reg         w_hold_reg;
	reg  [3:0]  awaddr_reg;
	reg  [31:0] wdata_reg;
	reg  [3:0]  wstrb_reg;
	wire [31:0] wmask;
	wire        wr_fire;
	wire        step;
	wire [7:0]  fld;
	wire [3:0]  bank;
	wire [11:0] w12;
	wire        lone;
	wire        tbl_op;
	wire [1:0]  pu_mode;

	// Instruction cycle phase counter
	always @(posedge aclk) begin
		if (!aresetn) begin
			phase_reg <= 2'h0;
		end else begin
			phase_reg <= phase_reg + 2'h1;
		end
	end
	assign cycle_start = (phase_reg == 2'h0);
	assign step = instr_valid && (phase_reg == `OFD_LAST_PHASE);

	// Field extraction; unused bits never looked at
	assign fld = instr_word[`OFD_F_HI:`OFD_F_LO];
	assign w12 = instr_word[`OFD_W12_HI:0];
	assign lone = (sec_reg == SEC_NONE) &&
		(instr_word[15:`OFD_SEC_LO] == `OFD_SEC_TAG) &&
		(instr_fmt == `OFD_FMT_NONE);
	assign bank = !instr_word[`OFD_A_POS] ?
		((fld < `OFD_ACC_SPLIT) ? `OFD_ACC_LO_BANK : `OFD_ACC_HI_BANK)
		: bank_reg;
	assign tbl_op = step && (sec_reg == SEC_NONE) && (instr_fmt == `OFD_FMT_TBL);
	assign pu_mode = instr_word[1:0];

	// Decode registers
	always @(posedge aclk) begin
		if (!aresetn) begin
			sec_reg        <= SEC_NONE;
			sfast_reg      <= 1'b0;
			dec_valid      <= 1'b0;
			data_addr      <= 12'h000;
			bit_sel        <= 8'h00;
			to_accum       <= 1'b0;
			to_file        <= 1'b0;
			move_src       <= 12'h000;
			move_dst       <= 12'h000;
			move_go        <= 1'b0;
			imm_value      <= 20'h00000;
			imm_width      <= 2'h0;
			jump_target    <= 20'h00000;
			jump_rel       <= 1'b0;
			jump_abs       <= 1'b0;
			shadow_save    <= 1'b0;
			shadow_restore <= 1'b0;
			tbl_addr       <= 21'h000000;
			tbl_go         <= 1'b0;
			lone_nop       <= 1'b0;
		end else begin
			dec_valid      <= step;
			move_go        <= 1'b0;
			jump_rel       <= 1'b0;
			jump_abs       <= 1'b0;
			shadow_save    <= 1'b0;
			shadow_restore <= 1'b0;
			tbl_go         <= 1'b0;
			lone_nop       <= 1'b0;
			to_accum       <= 1'b0;
			to_file        <= 1'b0;
			if (step && sec_reg != SEC_NONE) begin
				sec_reg <= SEC_NONE;
				case (sec_reg)
					SEC_MOVE: begin
						move_dst <= w12;
						move_go  <= 1'b1;
					end
					SEC_GOTO, SEC_CALL: begin
						jump_target <= {w12, jump_target[7:0]};
						imm_value   <= {w12, imm_value[7:0]};
						jump_abs    <= 1'b1;
						shadow_save <= (sec_reg == SEC_CALL) && sfast_reg;
					end
					default: begin
						imm_value <= {8'h00, imm_value[11:8], fld};
					end
				endcase
			end else if (step && lone) begin
				lone_nop <= 1'b1;
			end else if (step) begin
				case (instr_fmt)
					`OFD_FMT_BYTE: begin
						data_addr <= {bank, fld};
						to_accum  <= !instr_word[`OFD_D_POS];
						to_file   <= instr_word[`OFD_D_POS];
					end
					`OFD_FMT_BIT: begin
						data_addr <= {bank, fld};
						bit_sel   <= 8'h01 << instr_word[`OFD_B_HI:`OFD_B_LO];
						to_file   <= 1'b1;
					end
					`OFD_FMT_LIT8: begin
						imm_value <= {12'h000, fld};
						imm_width <= 2'h0;
					end
					`OFD_FMT_LIT12: begin
						imm_value <= {8'h00, instr_word[3:0], 8'h00};
						imm_width <= 2'h1;
						sec_reg   <= SEC_LIT;
					end
					`OFD_FMT_MOVE: begin
						move_src <= w12;
						sec_reg  <= SEC_MOVE;
					end
					`OFD_FMT_GOTO, `OFD_FMT_CALL: begin
						jump_target <= {12'h000, fld};
						imm_value   <= {12'h000, fld};
						imm_width   <= 2'h2;
						sfast_reg   <= (instr_fmt == `OFD_FMT_CALL) &&
							instr_word[`OFD_S_CALL_POS];
						sec_reg     <= (instr_fmt == `OFD_FMT_CALL) ? SEC_CALL : SEC_GOTO;
					end
					`OFD_FMT_BRA11: begin
						jump_target <= {{9{instr_word[10]}}, instr_word[10:0]};
						jump_rel    <= 1'b1;
					end
					`OFD_FMT_BR8: begin
						jump_target <= {{12{fld[7]}}, fld};
						jump_rel    <= 1'b1;
					end
					`OFD_FMT_RET: begin
						shadow_restore <= instr_word[`OFD_S_RET_POS];
					end
					`OFD_FMT_TBL: begin
						tbl_addr <= (pu_mode == `OFD_PU_PREINC) ? tptr_reg + 21'h1 : tptr_reg;
						tbl_go   <= 1'b1;
					end
					default: begin
						sec_reg <= SEC_NONE;
					end
				endcase
			end
		end
	end

	// AXI4-Lite write side
	assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
	assign s_axi_wready  = !w_hold_reg && !s_axi_bvalid;
	assign wr_fire = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
	assign wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
		{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_reg  <= 1'b0;
			w_hold_reg   <= 1'b0;
			awaddr_reg   <= 4'h0;
			wdata_reg    <= 32'h00000000;
			wstrb_reg    <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `OFD_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_reg <= 1'b1;
				awaddr_reg  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_reg <= 1'b1;
				wdata_reg  <= s_axi_wdata;
				wstrb_reg  <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_hold_reg  <= 1'b0;
				w_hold_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (awaddr_reg == `OFD_BANK_OFS || awaddr_reg == `OFD_TPTR_OFS ||
					awaddr_reg == `OFD_PROD_OFS || awaddr_reg == `OFD_STAT_OFS) begin
					s_axi_bresp <= `OFD_RESP_OKAY;
				end else begin
					s_axi_bresp <= `OFD_RESP_DECERR;
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Bank select, table pointer and product storage
	always @(posedge aclk) begin
		if (!aresetn) begin
			bank_reg <= `OFD_BANK_RST;
			tptr_reg <= `OFD_TPTR_RST;
			prod_reg <= `OFD_PROD_RST;
		end else begin
			if (wr_fire && awaddr_reg == `OFD_BANK_OFS && wstrb_reg[0]) begin
				bank_reg <= wdata_reg[3:0];
			end
			if (wr_fire && awaddr_reg == `OFD_TPTR_OFS) begin
				tptr_reg <= (tptr_reg & ~wmask[20:0]) | (wdata_reg[20:0] & wmask[20:0]);
			end else if (tbl_op && pu_mode != `OFD_PU_NONE) begin
				if (pu_mode == `OFD_PU_POSTDEC) begin
					tptr_reg <= tptr_reg - 21'h1;
				end else begin
					tptr_reg <= tptr_reg + 21'h1;
				end
			end
			if (mul_valid) begin
				prod_reg <= mul_result;
			end
		end
	end

	// AXI4-Lite read side
	assign s_axi_arready = !s_axi_rvalid;

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= `OFD_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= `OFD_RESP_OKAY;
			if (s_axi_araddr == `OFD_BANK_OFS) begin
				s_axi_rdata <= {28'h0000000, bank_reg};
			end else if (s_axi_araddr == `OFD_TPTR_OFS) begin
				s_axi_rdata <= {11'h000, tptr_reg};
			end else if (s_axi_araddr == `OFD_PROD_OFS) begin
				s_axi_rdata <= {16'h0000, prod_reg[15:8], prod_reg[7:0]};
			end else if (s_axi_araddr == `OFD_STAT_OFS) begin
				s_axi_rdata <= {12'h000, 1'b0, sec_reg, data_addr, 2'h0, phase_reg};
			end else begin
				s_axi_rdata <= 32'h00000000;
				s_axi_rresp <= `OFD_RESP_DECERR;
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule // ofd_operand_decoder
`default_nettype wire

// *** common/ofd_defs.vh ***
`ifndef OFD_DEFS_VH
`define OFD_DEFS_VH
// Register byte offsets
`define OFD_BANK_OFS     4'h0
`define OFD_TPTR_OFS     4'h4
`define OFD_PROD_OFS     4'h8
`define OFD_STAT_OFS     4'hc
// Reset values
`define OFD_BANK_RST     4'h0
`define OFD_TPTR_RST     21'h000000
`define OFD_PROD_RST     16'h0000
// Instruction format codes from the opcode map
`define OFD_FMT_NONE     4'h0
`define OFD_FMT_BYTE     4'h1
`define OFD_FMT_BIT      4'h2
`define OFD_FMT_LIT8     4'h3
`define OFD_FMT_MOVE     4'h4
`define OFD_FMT_GOTO     4'h5
`define OFD_FMT_CALL     4'h6
`define OFD_FMT_BRA11    4'h7
`define OFD_FMT_BR8      4'h8
`define OFD_FMT_TBL      4'h9
`define OFD_FMT_RET      4'ha
`define OFD_FMT_LIT12    4'hb
// Field positions
`define OFD_F_LO         0
`define OFD_F_HI         7
`define OFD_A_POS        8
`define OFD_D_POS        9
`define OFD_B_LO         9
`define OFD_B_HI         11
`define OFD_W12_HI       11
`define OFD_S_CALL_POS   8
`define OFD_S_RET_POS    0
`define OFD_SEC_LO       12
`define OFD_SEC_TAG      4'hf
// Pointer update modes
`define OFD_PU_NONE      2'h0
`define OFD_PU_POSTINC   2'h1
`define OFD_PU_POSTDEC   2'h2
`define OFD_PU_PREINC    2'h3
// Timing: oscillator periods per instruction cycle
`define OFD_PHASES       4
`define OFD_LAST_PHASE   2'h3
// Access window split and banks
`define OFD_ACC_SPLIT    8'h80
`define OFD_ACC_LO_BANK  4'h0
`define OFD_ACC_HI_BANK  4'hf
// AXI responses
`define OFD_RESP_OKAY    2'h0
`define OFD_RESP_DECERR  2'h3
`endif

// *** test/ofd_chk_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "ofd_defs.vh"
module ofd_chk (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic [15:0] instr_word,
	input wire logic [3:0]  instr_fmt,
	input wire logic        instr_valid,
	input wire logic        cycle_start,
	input wire logic        dec_valid,
	input wire logic [11:0] data_addr,
	input wire logic [7:0]  bit_sel,
	input wire logic        to_accum,
	input wire logic        to_file,
	input wire logic        move_go,
	input wire logic        tbl_go,
	input wire logic        lone_nop
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_phase_period: assert property (cycle_start |=> !cycle_start [*3] ##1 cycle_start)
		else $error("cycle_start period wrong");
	a_dec_timing: assert property (instr_valid ##1 cycle_start |-> dec_valid)
		else $error("dec_valid missing");
	a_dec_cause: assert property (dec_valid |-> cycle_start && $past(instr_valid))
		else $error("dec_valid without word");
	a_accum_dest: assert property (to_accum |-> !to_file && !$past(instr_word[9]))
		else $error("to_accum wrong");
	a_file_dest: assert property (dec_valid && $past(instr_fmt) == `OFD_FMT_BYTE
		|-> to_file == $past(instr_word[9]))
		else $error("to_file wrong");
	a_access_low: assert property (dec_valid && $past(instr_fmt == `OFD_FMT_BYTE
		&& !instr_word[8] && !instr_word[7]) |-> data_addr[11:8] == `OFD_ACC_LO_BANK)
		else $error("access bank wrong");
	a_loc_field: assert property (dec_valid && $past(instr_fmt) == `OFD_FMT_BYTE
		|-> data_addr[7:0] == $past(instr_word[7:0]))
		else $error("location wrong");
	a_bit_onehot: assert property (dec_valid && $past(instr_fmt) == `OFD_FMT_BIT
		|-> bit_sel == 8'h01 << $past(instr_word[11:9]))
		else $error("bit_sel wrong");
	a_lone_quiet: assert property (lone_nop |-> !to_file && !to_accum && !move_go && !tbl_go)
		else $error("lone word acted");
	cover property (dec_valid && to_file);
	cover property (move_go);
	cover property (tbl_go);
endmodule // ofd_chk
bind ofd_operand_decoder ofd_chk u_chk (.aclk(aclk), .aresetn(aresetn),
	.instr_word(instr_word), .instr_fmt(instr_fmt), .instr_valid(instr_valid),
	.cycle_start(cycle_start), .dec_valid(dec_valid), .data_addr(data_addr),
	.bit_sel(bit_sel), .to_accum(to_accum), .to_file(to_file), .move_go(move_go),
	.tbl_go(tbl_go), .lone_nop(lone_nop));
`default_nettype wire

// *** test/operand_field_decoder_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "ofd_defs.vh"
`define CHK(nm, ex, gt) begin num_checks = num_checks + 1; \
	if ((gt) !== (ex)) begin error_cnt = error_cnt + 1; \
	$display("unexpected %s exp %h got %h", nm, ex, gt); end end
module operand_field_decoder_tb;
	logic aclk = 0, aresetn = 0, instr_valid = 0, mul_valid = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	logic [15:0] instr_word = 0, mul_result = 0;
	logic [3:0] instr_fmt = 0, s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hf;
	logic [31:0] s_axi_wdata = 0;
	wire cycle_start, dec_valid, to_accum, to_file, move_go, jump_rel, jump_abs;
	wire shadow_save, shadow_restore, tbl_go, lone_nop, s_axi_awready, s_axi_wready;
	wire s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [11:0] data_addr, move_src, move_dst;
	wire [7:0] bit_sel;
	wire [19:0] imm_value, jump_target;
	wire [1:0] imm_width, s_axi_bresp, s_axi_rresp;
	wire [20:0] tbl_addr;
	wire [31:0] s_axi_rdata;
	integer error_cnt = 0, num_checks = 0, k;
	logic [1:0] r, pu;
	logic [20:0] p, ea;
	logic [31:0] d;
	ofd_operand_decoder dut (
		.aclk(aclk), .aresetn(aresetn), .instr_word(instr_word), .instr_fmt(instr_fmt),
		.instr_valid(instr_valid), .mul_valid(mul_valid), .mul_result(mul_result),
		.cycle_start(cycle_start), .dec_valid(dec_valid), .data_addr(data_addr),
		.bit_sel(bit_sel), .to_accum(to_accum), .to_file(to_file), .move_src(move_src),
		.move_dst(move_dst), .move_go(move_go), .imm_value(imm_value), .imm_width(imm_width),
		.jump_target(jump_target), .jump_rel(jump_rel), .jump_abs(jump_abs),
		.shadow_save(shadow_save), .shadow_restore(shadow_restore), .tbl_addr(tbl_addr),
		.tbl_go(tbl_go), .lone_nop(lone_nop), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready));
	always #25 aclk = ~aclk;
	task wrap_up;
		begin
			$display("checks %0d errors %0d", num_checks, error_cnt);
			if (error_cnt == 0 && num_checks > 0)
				$display("bench passed");
			else
				$display("bench failed");
			$finish;
		end
	endtask
	task tmo;
		begin
			`CHK("timeout", 1'b0, 1'b1)
			wrap_up;
		end
	endtask
	// One word on the phase-3 sampling edge
	task issue(input [15:0] w, input [3:0] f);
		integer i;
		begin
			for (i = 0; i < 9 && cycle_start !== 1'b1; i = i + 1) @(posedge aclk) #1;
			if (i == 9) tmo;
			repeat (3) @(posedge aclk);
			instr_word <= w;
			instr_fmt <= f;
			instr_valid <= 1;
			@(posedge aclk);
			instr_valid <= 0;
			#1;
		end
	endtask
	task axw(input [3:0] a, input [31:0] v, output [1:0] rs);
		integer i;
		bit dn;
		begin
			dn = 0;
			@(posedge aclk);
			s_axi_awaddr <= a;
			s_axi_wdata <= v;
			s_axi_awvalid <= 1;
			s_axi_wvalid <= 1;
			s_axi_bready <= 1;
			for (i = 0; i < 20 && !dn; i = i + 1) begin
				@(posedge aclk);
				if (s_axi_awready) s_axi_awvalid <= 0;
				if (s_axi_wready) s_axi_wvalid <= 0;
				if (s_axi_bvalid) begin
					rs = s_axi_bresp;
					s_axi_bready <= 0;
					dn = 1;
				end
			end
			if (!dn) tmo;
			#1;
		end
	endtask
	task axr(input [3:0] a, output [31:0] v, output [1:0] rs);
		integer i;
		bit dn;
		begin
			dn = 0;
			@(posedge aclk);
			s_axi_araddr <= a;
			s_axi_arvalid <= 1;
			s_axi_rready <= 1;
			for (i = 0; i < 20 && !dn; i = i + 1) begin
				@(posedge aclk);
				if (s_axi_arready) s_axi_arvalid <= 0;
				if (s_axi_rvalid) begin
					v = s_axi_rdata;
					rs = s_axi_rresp;
					s_axi_rready <= 0;
					dn = 1;
				end
			end
			if (!dn) tmo;
			#1;
		end
	endtask
	task rd(input [3:0] a, input [31:0] e);
		begin
			axr(a, d, r);
			`CHK("rdata", e, d)
			`CHK("rresp", `OFD_RESP_OKAY, r)
		end
	endtask
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk) #1;
		`CHK("dec_valid", 1'b0, dec_valid)
		rd(`OFD_BANK_OFS, 32'h0);
		rd(`OFD_TPTR_OFS, 32'h0);
		axw(`OFD_BANK_OFS, 32'h5, r);
		`CHK("bresp", `OFD_RESP_OKAY, r)
		rd(`OFD_BANK_OFS, 32'h5);
		issue(16'h0334, `OFD_FMT_BYTE);
		`CHK("dec_valid", 1'b1, dec_valid)
		`CHK("data_addr", 12'h534, data_addr)
		`CHK("to_file", 1'b1, to_file)
		issue(16'hfc34, `OFD_FMT_BYTE);
		`CHK("data_addr", 12'h034, data_addr)
		`CHK("to_accum", 1'b1, to_accum)
		issue(16'h00ff, `OFD_FMT_BYTE);
		`CHK("data_addr", 12'hfff, data_addr)
		for (k = 0; k < 8; k = k + 1) begin
			issue({4'h8, k[2:0], 1'b1, 8'h10}, `OFD_FMT_BIT);
			`CHK("bit_sel", 8'h01 << k, bit_sel)
		end
		issue(16'hc123, `OFD_FMT_MOVE);
		`CHK("move_src", 12'h123, move_src)
		issue(16'hffed, `OFD_FMT_NONE);
		`CHK("move_dst", 12'hfed, move_dst)
		`CHK("move_go", 1'b1, move_go)
		`CHK("lone_nop", 1'b0, lone_nop)
		issue(16'hf5a5, `OFD_FMT_NONE);
		`CHK("lone_nop", 1'b1, lone_nop)
		issue(16'h0e7f, `OFD_FMT_LIT8);
		`CHK("imm", 22'h00007f, {imm_width, imm_value})
		issue(16'h0005, `OFD_FMT_LIT12);
		issue(16'hf0a7, `OFD_FMT_NONE);
		`CHK("imm", 22'h1005a7, {imm_width, imm_value})
		issue(16'hef34, `OFD_FMT_GOTO);
		issue(16'hf9ab, `OFD_FMT_NONE);
		`CHK("jump", 21'h19ab34, {jump_abs, jump_target})
		issue(16'hd7fe, `OFD_FMT_BRA11);
		`CHK("jump", 21'h1ffffe, {jump_rel, jump_target})
		issue(16'he280, `OFD_FMT_BR8);
		`CHK("jump", 21'h1fff80, {jump_rel, jump_target})
		for (k = 0; k < 2; k = k + 1) begin
			issue({7'h76, k[0], 8'h12}, `OFD_FMT_CALL);
			issue(16'hf000, `OFD_FMT_NONE);
			`CHK("shadow_save", k[0], shadow_save)
			issue({15'h0009, k[0]}, `OFD_FMT_RET);
			`CHK("shadow_restore", k[0], shadow_restore)
		end
		axw(`OFD_TPTR_OFS, 32'hffffffff, r);
		rd(`OFD_TPTR_OFS, 32'h001fffff);
		p = 21'h1fffff;
		for (k = 0; k < 4; k = k + 1) begin
			pu = k[1:0] + 2'h1;
			ea = (pu == `OFD_PU_PREINC) ? p + 21'h1 : p;
			if (pu == `OFD_PU_POSTINC || pu == `OFD_PU_PREINC) p = p + 21'h1;
			if (pu == `OFD_PU_POSTDEC) p = p - 21'h1;
			issue({14'h0002, pu}, `OFD_FMT_TBL);
			`CHK("tbl", {1'b1, ea}, {tbl_go, tbl_addr})
			rd(`OFD_TPTR_OFS, {11'h0, p});
		end
		@(posedge aclk);
		mul_result <= 16'hbeef;
		mul_valid <= 1;
		@(posedge aclk);
		mul_valid <= 0;
		rd(`OFD_PROD_OFS, 32'h0000beef);
		axw(`OFD_PROD_OFS, 32'h1234, r);
		rd(`OFD_PROD_OFS, 32'h0000beef);
		axw(4'h2, 32'h1, r);
		`CHK("bresp", `OFD_RESP_DECERR, r)
		axr(4'h2, d, r);
		`CHK("rresp", `OFD_RESP_DECERR, r)
		wrap_up;
	end
endmodule // operand_field_decoder_tb
`default_nettype wire
